/* logic/lcrb_top.sv */
// Our own choice: strobed register access.
`timescale 1ns/1ps
`include "lcrb_defines.svh"

module lcrb_top #(
   parameter int STEP_CYCLES = `LCRB_STEP_CYC
) (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   input  wire logic        hdr_valid,
   input  wire logic [1:0]  hdr_vc,
   input  wire logic        hdr_interleaved,
   input  wire logic [31:0] hdr_raw,
   input  wire logic [31:0] hdr_fixed,
   output logic      [31:0] hdr_view,
   input  wire logic [3:0]  lp_ctrl_pin,
   output logic      [3:0]  lp_ctrl_out,
   output logic             startup_active,
   input  wire logic        i2c_txn_valid,
   input  wire logic [6:0]  i2c_addr,
   input  wire logic        i2c_decode_match,
   input  wire logic        i2c_alias_hit,
   input  wire logic [6:0]  i2c_alias_addr,
   output logic             i2c_fwd_valid,
   output logic      [6:0]  i2c_fwd_addr,
   input  wire logic        i2c_wr_req,
   input  wire logic        fc_locked,
   input  wire logic        remote_ack,
   output logic             i2c_local_ack,
   input  wire logic        bc_valid,
   input  wire logic [7:0]  bc_data,
   input  wire logic        bc_parity,
   output logic             bc_parity_err,
   input  wire logic        seq_valid,
   input  wire logic [7:0]  seq_byte,
   output logic             seq_ready,
   output logic             seq_out_valid,
   output logic      [7:0]  seq_out_byte,
   output logic      [3:0]  fwd_gpio_en,
   input  wire logic        bc_link_detect,
   input  wire logic        remote_self_test_req,
   input  wire logic        remote_multi_port,
   input  wire logic [3:0]  remote_port_num,
   output logic             link_self_test_flag,
   output logic             partner_multi_input_capable,
   output logic      [3:0]  partner_port_num
);

   ////////////////////////////////////////////////////////////////////////
   // Register file

   logic [7:0] hdr_ctrl_q;
   logic [7:0] bc_cfg_q;
   logic [7:0] dp_ctl_q;
   logic [7:0] pcap_q;
   logic [7:0] rd_mux;
   logic [7:0] rdata_q;

   function automatic logic [7:0] rsvd_value(input logic [7:0] a);
      case (a)
         `LCRB_ADDR_RSVD_A: rsvd_value = `LCRB_RST_RSVD_A;
         `LCRB_ADDR_RSVD_B: rsvd_value = `LCRB_RST_RSVD_B;
         `LCRB_ADDR_RSVD_C: rsvd_value = `LCRB_RST_RSVD_C;
         default:           rsvd_value = `LCRB_RST_RSVD_ZERO;
      endcase
   endfunction : rsvd_value

   function automatic logic [3:0] gpio_mask(input logic [1:0] code);
      case (code)
         2'h0:    gpio_mask = 4'h0;
         2'h1:    gpio_mask = 4'h1;
         2'h2:    gpio_mask = 4'h3;
         default: gpio_mask = 4'hf;
      endcase
   endfunction : gpio_mask

   wire wr_hdr  = reg_wr && (reg_addr == `LCRB_ADDR_HDR_CTRL);
   wire wr_bc   = reg_wr && (reg_addr == `LCRB_ADDR_BC_CFG);
   wire wr_dp   = reg_wr && (reg_addr == `LCRB_ADDR_DP_CTL);
   wire wr_pcap = reg_wr && (reg_addr == `LCRB_ADDR_PCAP);

   // Reserved bits stay at reset value, writes land on live fields only
   // reserved bits held
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         hdr_ctrl_q <= `LCRB_RST_HDR_CTRL;
         bc_cfg_q   <= `LCRB_RST_BC_CFG;
         dp_ctl_q   <= `LCRB_RST_DP_CTL;
      end else begin
         if (wr_hdr) begin
            hdr_ctrl_q <= (reg_wdata & 8'hf7)
                          | (`LCRB_RST_HDR_CTRL & 8'h08);
         end
         if (wr_bc) begin
            bc_cfg_q <= (reg_wdata & 8'he8) | (`LCRB_RST_BC_CFG & 8'h17);
         end
         if (wr_dp) begin
            dp_ctl_q <= (reg_wdata & 8'h07) | (`LCRB_RST_DP_CTL & 8'hf8);
         end
      end
   end

   // A software write wins over the automatic load in the same cycle
   // automatic capability load
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pcap_q <= `LCRB_RST_PCAP;
      end else if (wr_pcap) begin
         pcap_q <= reg_wdata & 8'hbf;
      end else if (bc_link_detect && !pcap_q[`LCRB_PC_FREEZE]) begin
         pcap_q <= {1'b0, 1'b0, remote_self_test_req, remote_multi_port,
                    remote_port_num};
      end
   end

   always_comb begin
      case (reg_addr)
         `LCRB_ADDR_HDR_CTRL: rd_mux = hdr_ctrl_q;
         `LCRB_ADDR_BC_CFG:   rd_mux = bc_cfg_q;
         `LCRB_ADDR_DP_CTL:   rd_mux = dp_ctl_q;
         `LCRB_ADDR_PCAP:     rd_mux = pcap_q;
         default: begin
            if ((reg_addr >= `LCRB_ADDR_RSVD_A
                 && reg_addr <= `LCRB_ADDR_RSVD_E_HI)
                || reg_addr == `LCRB_ADDR_RSVD_F) begin
               rd_mux = rsvd_value(reg_addr);
            end else begin
               rd_mux = 8'h00;
            end
         end
      endcase
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= reg_rd ? rd_mux : 8'h00;
      end
   end

   assign reg_rdata = rdata_q;

   assign link_self_test_flag         = pcap_q[`LCRB_PC_SELF_TEST];
   assign partner_multi_input_capable = pcap_q[`LCRB_PC_MULTI];
   assign partner_port_num            = pcap_q[`LCRB_PC_PORT];

   ////////////////////////////////////////////////////////////////////////
   // Packet header capture

   wire [1:0] hdr_sel   = hdr_ctrl_q[`LCRB_HC_SEL];
   wire       hdr_fix   = hdr_ctrl_q[`LCRB_HC_FIXED];
   wire       hdr_pervc = hdr_ctrl_q[`LCRB_HC_PERVC];

   lcrb_pkg::lcrb_hdr_t vc_raw_q [4];
   lcrb_pkg::lcrb_hdr_t vc_fix_q [4];
   lcrb_pkg::lcrb_hdr_t last_raw_q;
   lcrb_pkg::lcrb_hdr_t last_fix_q;
   lcrb_pkg::lcrb_hdr_t view_q;

   genvar gv;
   generate
      for (gv = 0; gv < 4; gv++) begin : g_vc
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               vc_raw_q[gv] <= 32'h00000000;
               vc_fix_q[gv] <= 32'h00000000;
            end else if (hdr_valid && hdr_interleaved && hdr_pervc
                         && hdr_vc == 2'(gv)) begin
               vc_raw_q[gv] <= hdr_raw;
               vc_fix_q[gv] <= hdr_fixed;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         last_raw_q <= 32'h00000000;
         last_fix_q <= 32'h00000000;
      end else if (hdr_valid) begin
         last_raw_q <= hdr_raw;
         last_fix_q <= hdr_fixed;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         view_q <= 32'h00000000;
      end else if (hdr_pervc) begin
         view_q <= hdr_fix ? vc_fix_q[hdr_sel] : vc_raw_q[hdr_sel];
      end else begin
         view_q <= hdr_fix ? last_fix_q : last_raw_q;
      end
   end

   assign hdr_view = view_q;

   ////////////////////////////////////////////////////////////////////////
   // Startup interval on LP control

   logic [3:0] lp_meta_q;
   logic [3:0] lp_sync_q;
   logic [3:0] lp_out_q;
   logic       ign;

   lcrb_startup_timer #(
      .STEP_CYCLES (STEP_CYCLES)
   ) u_timer (
      .clk_sys       (clk_sys),
      .rst           (rst),
      .period_code   (hdr_ctrl_q[`LCRB_HC_STARTUP_INTERVAL]),
      .ignore_active (ign)
   );

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         lp_meta_q <= 4'h0;
         lp_sync_q <= 4'h0;
      end else begin
         lp_meta_q <= lp_ctrl_pin;
         lp_sync_q <= lp_meta_q;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         lp_out_q <= 4'h0;
      end else begin
         lp_out_q <= ign ? 4'h0 : lp_sync_q;
      end
   end

   assign lp_ctrl_out    = lp_out_q;
   assign startup_active = ign;

   ////////////////////////////////////////////////////////////////////////
   // I2C pass-through, remap and acknowledge

   logic       fwd_q;
   logic [6:0] fwd_addr_q;
   logic       ack_q;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         fwd_q      <= 1'b0;
         fwd_addr_q <= 7'h00;
      end else begin
         fwd_q <= i2c_txn_valid
                  && (bc_cfg_q[`LCRB_BC_PASS_ALL]
                      || (bc_cfg_q[`LCRB_BC_PASS_MATCH] && i2c_decode_match));
         if (i2c_txn_valid) begin
            fwd_addr_q <= i2c_alias_hit ? i2c_alias_addr : i2c_addr;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= i2c_wr_req && (bc_cfg_q[`LCRB_BC_AUTO_ACK]
                                 || (fc_locked && remote_ack));
      end
   end

   assign i2c_fwd_valid = fwd_q;
   assign i2c_fwd_addr  = fwd_addr_q;
   assign i2c_local_ack = ack_q;

   ////////////////////////////////////////////////////////////////////////
   // Back-channel parity

   logic par_err_q;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         par_err_q <= 1'b0;
      end else begin
         par_err_q <= bc_valid && bc_cfg_q[`LCRB_BC_PARITY_EN]
                      && ((^bc_data) != bc_parity);
      end
   end

   assign bc_parity_err = par_err_q;

   ////////////////////////////////////////////////////////////////////////
   // Control sequence with appended check word

   lcrb_pkg::lcrb_seq_state_t st_q;
   logic [2:0] cnt_q;
   logic       out_v_q;
   logic [7:0] out_b_q;
   logic [7:0] crc_val;

   wire crc_en  = dp_ctl_q[`LCRB_DP_CRC_EN];
   wire take    = seq_valid && seq_ready;
   wire last_db = take && (cnt_q == `LCRB_SEQ_DATA_BYTES);

   // Source stalls for one cycle while the check word goes out
   assign seq_ready = (st_q == lcrb_pkg::SEQ_DATA);

   lcrb_crc8 u_crc (
      .clk_sys (clk_sys),
      .rst     (rst),
      .clear   ((st_q == lcrb_pkg::SEQ_CRC) || (last_db && !crc_en)),
      .en      (take),
      .data    (seq_byte),
      .crc_q   (crc_val)
   );

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_q    <= lcrb_pkg::SEQ_DATA;
         cnt_q   <= 3'h0;
         out_v_q <= 1'b0;
         out_b_q <= 8'h00;
      end else begin
         case (st_q)
            lcrb_pkg::SEQ_DATA: begin
               out_v_q <= take;
               if (take) begin
                  out_b_q <= seq_byte;
                  cnt_q   <= cnt_q + 3'h1;
               end
               if (last_db && crc_en) begin
                  st_q <= lcrb_pkg::SEQ_CRC;
               end
            end
            lcrb_pkg::SEQ_CRC: begin
               out_v_q <= 1'b1;
               out_b_q <= crc_val;
               st_q    <= lcrb_pkg::SEQ_DATA;
            end
            default: begin
               st_q <= lcrb_pkg::SEQ_DATA;
            end
         endcase
      end
   end

   assign seq_out_valid = out_v_q;
   assign seq_out_byte  = out_b_q;

   assign fwd_gpio_en = gpio_mask(dp_ctl_q[`LCRB_DP_GPIO]);

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_hdr_vc_fixed: assert property (
      hdr_valid && hdr_interleaved && hdr_pervc && hdr_fix
      && hdr_vc == hdr_sel && !reg_wr ##1 !hdr_valid && !reg_wr
      |=> hdr_view == $past(hdr_fixed, 2))
      else $error("selected channel header not shown");

   a_hdr_raw_view: assert property (
      hdr_valid && !hdr_pervc && !hdr_fix && !reg_wr
      ##1 !hdr_valid && !reg_wr |=> hdr_view == $past(hdr_raw, 2))
      else $error("raw header not shown");

   a_lp_ignored: assert property (
      startup_active |=> lp_ctrl_out == 4'h0)
      else $error("LP control passed during startup interval");

   a_pass_all_fwd: assert property (
      i2c_txn_valid && bc_cfg_q[`LCRB_BC_PASS_ALL] |=> i2c_fwd_valid)
      else $error("pass-all transaction not forwarded");

   a_no_match_drop: assert property (
      i2c_txn_valid && !bc_cfg_q[`LCRB_BC_PASS_ALL]
      && !(bc_cfg_q[`LCRB_BC_PASS_MATCH] && i2c_decode_match)
      |=> !i2c_fwd_valid)
      else $error("transaction forwarded without permission");

   a_alias_remap: assert property (
      i2c_txn_valid && i2c_alias_hit
      |=> i2c_fwd_addr == $past(i2c_alias_addr))
      else $error("alias address not remapped");

   a_auto_ack_all: assert property (
      i2c_wr_req && bc_cfg_q[`LCRB_BC_AUTO_ACK] |=> i2c_local_ack)
      else $error("write not auto acknowledged");

   a_parity_off: assert property (
      bc_valid && !bc_cfg_q[`LCRB_BC_PARITY_EN] |=> !bc_parity_err)
      else $error("parity error with check disabled");

   a_crc_ninth: assert property (
      last_db && crc_en |=> seq_out_valid && !seq_ready
      ##1 seq_out_valid && seq_out_byte == $past(crc_val))
      else $error("check word not sent as ninth byte");

   a_gpio_four: assert property (
      dp_ctl_q[`LCRB_DP_GPIO] == 2'h3 |-> fwd_gpio_en == 4'hf)
      else $error("four GPIO lanes not enabled");

   a_cap_frozen: assert property (
      pcap_q[`LCRB_PC_FREEZE] && !wr_pcap |=> $stable(pcap_q))
      else $error("frozen capabilities changed");

   a_cap_load: assert property (
      bc_link_detect && !pcap_q[`LCRB_PC_FREEZE] && !wr_pcap
      |=> partner_port_num == $past(remote_port_num)
      && partner_multi_input_capable == $past(remote_multi_port))
      else $error("capabilities not loaded on link");

   c_crc_sent: cover property (last_db && crc_en ##2 seq_out_valid);
   c_vc_capture: cover property (hdr_valid && hdr_interleaved && hdr_pervc);
   c_startup_end: cover property ($fell(startup_active));
   c_cap_frozen: cover property (bc_link_detect && pcap_q[`LCRB_PC_FREEZE]);

endmodule : lcrb_top

/* logic/lcrb_defines.svh */
`ifndef LCRB_DEFINES_SVH
`define LCRB_DEFINES_SVH

// Register offsets
`define LCRB_ADDR_RSVD_A      8'h28
`define LCRB_ADDR_RSVD_B      8'h29
`define LCRB_ADDR_RSVD_C      8'h2a
`define LCRB_ADDR_RSVD_D_LO   8'h2b
`define LCRB_ADDR_RSVD_D_HI   8'h2d
`define LCRB_ADDR_RSVD_E_LO   8'h2e
`define LCRB_ADDR_RSVD_E_HI   8'h30
`define LCRB_ADDR_HDR_CTRL    8'h31
`define LCRB_ADDR_BC_CFG      8'h32
`define LCRB_ADDR_DP_CTL      8'h33
`define LCRB_ADDR_RSVD_F      8'h34
`define LCRB_ADDR_PCAP        8'h35

// Reset values, reserved bits included
`define LCRB_RST_RSVD_A       8'h07
`define LCRB_RST_RSVD_B       8'h33
`define LCRB_RST_RSVD_C       8'h01
`define LCRB_RST_RSVD_ZERO    8'h00
`define LCRB_RST_HDR_CTRL     8'h20
`define LCRB_RST_BC_CFG       8'h09
`define LCRB_RST_DP_CTL       8'h04
`define LCRB_RST_PCAP         8'h00

// Field positions
`define LCRB_HC_SEL           7:6
`define LCRB_HC_FIXED         5
`define LCRB_HC_PERVC         4
`define LCRB_HC_STARTUP_INTERVAL         2:0
`define LCRB_BC_PASS_ALL      7
`define LCRB_BC_PASS_MATCH    6
`define LCRB_BC_AUTO_ACK      5
`define LCRB_BC_PARITY_EN     3
`define LCRB_DP_CRC_EN        2
`define LCRB_DP_GPIO          1:0
`define LCRB_PC_FREEZE        7
`define LCRB_PC_SELF_TEST     5
`define LCRB_PC_MULTI         4
`define LCRB_PC_PORT          3:0

// Sequence and check word
`define LCRB_SEQ_DATA_BYTES   3'd7
`define LCRB_CRC_POLY         8'h07
`define LCRB_CRC_INIT         8'h00

// Startup interval step
`define LCRB_STEP_US          100
`define LCRB_CLK_MHZ          250
`define LCRB_STEP_CYC         (`LCRB_STEP_US * `LCRB_CLK_MHZ)
`define LCRB_STEP_MAX         4'd8

`endif

/* logic/lcrb_pkg.sv */
package lcrb_pkg;

   typedef enum logic [0:0] {
      SEQ_DATA = 1'b0,
      SEQ_CRC  = 1'b1
   } lcrb_seq_state_t;

   typedef logic [7:0]  lcrb_byte_t;
   typedef logic [31:0] lcrb_hdr_t;

endpackage : lcrb_pkg

/* logic/lcrb_startup_timer.sv */
`timescale 1ns/1ps
`include "lcrb_defines.svh"

module lcrb_startup_timer #(
   parameter int STEP_CYCLES = `LCRB_STEP_CYC
) (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic [2:0] period_code,
   output logic            ignore_active
);

   logic [15:0] cyc_q;
   logic [3:0]  step_q;

   // Period code read live, so a late write still shortens or stretches
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cyc_q  <= 16'h0000;
         step_q <= 4'h0;
      end else if (step_q != `LCRB_STEP_MAX) begin
         if (cyc_q == 16'(STEP_CYCLES - 1)) begin
            cyc_q  <= 16'h0000;
            step_q <= step_q + 4'h1;
         end else begin
            cyc_q <= cyc_q + 16'h0001;
         end
      end
   end

   assign ignore_active = (step_q <= {1'b0, period_code});

endmodule : lcrb_startup_timer

/* logic/lcrb_crc8.sv */
`timescale 1ns/1ps
`include "lcrb_defines.svh"

module lcrb_crc8 (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       clear,
   input  wire logic       en,
   input  wire logic [7:0] data,
   output logic      [7:0] crc_q
);

   logic [7:0] crc_d;

   always_comb begin
      crc_d = crc_q ^ data;
      for (int i = 0; i < 8; i++) begin
         crc_d = crc_d[7] ? ((crc_d << 1) ^ `LCRB_CRC_POLY) : (crc_d << 1);
      end
   end

   // Clear wins so a fresh group never inherits a stale check word
   always_ff @(posedge clk_sys) begin
      if (rst || clear) begin
         crc_q <= `LCRB_CRC_INIT;
      end else if (en) begin
         crc_q <= crc_d;
      end
   end

endmodule : lcrb_crc8

/* tb/lcrb_remote_des.sv */
`timescale 1ns/1ps
module lcrb_remote_des (
   input  wire logic       clk_sys,
   output logic            bc_link_detect,
   output logic            remote_self_test_req,
   output logic            remote_multi_port,
   output logic      [3:0] remote_port_num,
   output logic            bc_valid,
   output logic      [7:0] bc_data,
   output logic            bc_parity,
   output logic            fc_locked,
   output logic            remote_ack
);
   initial begin
      {bc_link_detect, bc_valid, fc_locked, remote_ack} = 4'h0;
      {remote_self_test_req, remote_multi_port, remote_port_num} = 6'h00;
      {bc_parity, bc_data} = 9'h0aa;
   end
   task automatic status(input logic lock, input logic ack);
      fc_locked  <= lock;
      remote_ack <= ack;
   endtask : status
   // Link comes up announcing its capabilities
   task automatic link(input logic [5:0] cap);
      @(posedge clk_sys);
      bc_link_detect <= 1'b1;
      {remote_self_test_req, remote_multi_port, remote_port_num} <= cap;
   endtask : link
   // Released lines invert, so stale data fails parity unless the byte was sent with bad parity
   task automatic bc_send(input logic [7:0] d, input logic bad);
      @(posedge clk_sys);
      bc_valid  <= 1'b1;
      bc_data   <= d;
      bc_parity <= ^d ^ bad;
      @(posedge clk_sys);
      bc_valid  <= 1'b0;
      bc_data   <= ~d;
      bc_parity <= ~(^d ^ bad);
   endtask : bc_send
endmodule : lcrb_remote_des

/* tb/lcrb_top_tb_top.sv */
`timescale 1ns/1ps
module lcrb_top_tb_top;
   localparam int STEP = 10;
   localparam logic [7:0] RA[11] = '{8'h28, 8'h29, 8'h2a, 8'h2c, 8'h2f,
      8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h40};
   localparam logic [7:0] RV[11] = '{8'h07, 8'h33, 8'h01, 8'h00, 8'h00,
      8'h20, 8'h09, 8'h04, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] WV[11] = '{8'h07, 8'h33, 8'h01, 8'h00, 8'h00,
      8'hf7, 8'he9, 8'h07, 8'h00, 8'hbf, 8'h00};
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, bc_data, seq_byte;
   logic [7:0]  seq_out_byte;
   logic        reg_wr, reg_rd, hdr_valid, hdr_interleaved, i2c_txn_valid;
   logic        i2c_decode_match, i2c_alias_hit, i2c_fwd_valid, i2c_wr_req;
   logic        fc_locked, remote_ack, i2c_local_ack, bc_valid, bc_parity;
   logic        bc_parity_err, seq_valid, seq_ready, seq_out_valid;
   logic        bc_link_detect, remote_self_test_req, remote_multi_port;
   logic        link_self_test_flag, partner_multi_input_capable;
   logic        startup_active;
   logic [1:0]  hdr_vc;
   logic [31:0] hdr_raw, hdr_fixed, hdr_view;
   logic [3:0]  lp_ctrl_pin, lp_ctrl_out, fwd_gpio_en, remote_port_num;
   logic [3:0]  partner_port_num;
   logic [6:0]  i2c_addr, i2c_alias_addr, i2c_fwd_addr;
   int          n_mismatch = 0;
   int          compares = 0;
   int          n_stall = 0;
   logic [7:0]  outq[$];

   lcrb_top #(.STEP_CYCLES(STEP)) dut (.*);
   lcrb_remote_des partner (.*);

   always #2 clk_sys = ~clk_sys;
   // Bytes out and source stalls, seen before the edge updates them
   always @(posedge clk_sys) begin
      if (seq_out_valid === 1'b1) outq.push_back(seq_out_byte);
      if (seq_ready === 1'b0) n_stall++;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("Compares %0d, mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   // Data stands only in the cycle after the strobe
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask : rchk
   task automatic hdr(input logic [1:0] vc, input logic il);
      @(posedge clk_sys);
      hdr_valid       <= 1'b1;
      hdr_vc          <= vc;
      hdr_interleaved <= il;
      hdr_raw         <= $urandom;
      hdr_fixed       <= $urandom;
      @(posedge clk_sys);
      hdr_valid <= 1'b0;
   endtask : hdr
   task automatic seq_put(input logic [7:0] v);
      @(posedge clk_sys);
      seq_valid <= 1'b1;
      seq_byte  <= v;
      @(posedge clk_sys);
      seq_valid <= 1'b0;
      seq_byte  <= ~v;
   endtask : seq_put
   function automatic logic [3:0] gmask(input logic [1:0] c);
      return (c == 2'd3) ? 4'hf : 4'((5'h1 << c) - 5'h1);
   endfunction : gmask
   function automatic logic [7:0] crc8(input logic [7:0] b[8]);
      logic [7:0] c = 8'h00;
      foreach (b[i]) begin
         c = c ^ b[i];
         repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
      end
      return c;
   endfunction : crc8
   ////////////////////////////////////////////////////////////////////////
   initial begin : watchdog
      repeat (8000) @(posedge clk_sys);
      n_mismatch++;
      report_and_stop();
   end
   initial begin : main
      logic [7:0]  d;
      logic [7:0]  b[8];
      logic [31:0] f[4];
      logic [31:0] p;
      void'($urandom(32'hb1fb1290));
      {reg_addr, reg_wdata, reg_wr, reg_rd, hdr_valid, hdr_vc} = '0;
      {hdr_interleaved, hdr_raw, hdr_fixed, lp_ctrl_pin, i2c_txn_valid} = '0;
      {i2c_addr, i2c_decode_match, i2c_alias_hit, i2c_alias_addr} = '0;
      {i2c_wr_req, seq_valid, seq_byte} = '0;
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      // Longest code set before the shortest one has run out
      wr(8'h31, 8'h27);
      lp_ctrl_pin <= 4'($urandom) | 4'h1;
      repeat (58) @(posedge clk_sys);
      #1 chk({startup_active, lp_ctrl_out}, 5'h10);
      repeat (30) @(posedge clk_sys);
      #1 chk({startup_active, lp_ctrl_out}, {1'b0, lp_ctrl_pin});
      wr(8'h31, 8'h20);
      $display("startup test done");
      foreach (RA[i]) rchk(RA[i], RV[i]);
      foreach (RA[i]) begin
         wr(RA[i], 8'hff);
         rchk(RA[i], WV[i]);
      end
      for (int c = 0; c < 4; c++) begin
         wr(8'h33, 8'(c));
         @(posedge clk_sys);
         #1 chk(fwd_gpio_en, gmask(2'(c)));
      end
      $display("register test done");
      for (int i = 0; i < 24; i++) begin
         d = (i == 0) ? 8'h20 : 8'($urandom);
         wr(8'h32, {d[7:5], 5'h08});
         partner.status(d[2], d[3]);
         @(posedge clk_sys);
         i2c_txn_valid    <= 1'b1;
         i2c_wr_req       <= 1'b1;
         i2c_addr         <= 7'($urandom);
         i2c_alias_addr   <= 7'($urandom);
         i2c_decode_match <= d[0];
         i2c_alias_hit    <= d[1];
         @(posedge clk_sys);
         i2c_txn_valid <= 1'b0;
         i2c_wr_req    <= 1'b0;
         #1 chk(i2c_fwd_valid, d[7] | (d[6] & d[0]));
         p = d[1] ? i2c_alias_addr : i2c_addr;
         chk(i2c_fwd_addr, p);
         chk(i2c_local_ack, d[5] | (d[2] & d[3]));
      end
      for (int i = 0; i < 8; i++) begin
         d = 8'($urandom);
         wr(8'h32, {4'h0, d[0], 3'h1});
         partner.bc_send(8'($urandom), d[1]);
         #1 chk(bc_parity_err, d[0] & d[1]);
      end
      $display("control channel test done");
      wr(8'h31, 8'h20);
      hdr(2'd0, 1'b0);
      repeat (2) @(posedge clk_sys);
      #1 chk(hdr_view, hdr_fixed);
      wr(8'h31, 8'h00);
      repeat (2) @(posedge clk_sys);
      #1 chk(hdr_view, hdr_raw);
      wr(8'h31, 8'h30);
      for (int v = 0; v < 4; v++) begin
         hdr(2'(v), 1'b1);
         f[v] = hdr_fixed;
      end
      // Plain packet must leave the per-channel store alone
      hdr(2'd1, 1'b0);
      p = hdr_fixed;
      for (int v = 0; v < 4; v++) begin
         wr(8'h31, {2'(v), 6'h30});
         repeat (2) @(posedge clk_sys);
         #1 chk(hdr_view, f[v]);
      end
      wr(8'h31, 8'he0);
      repeat (2) @(posedge clk_sys);
      #1 chk(hdr_view, p);
      $display("header test done");
      wr(8'h35, 8'h00);
      d = 8'($urandom);
      partner.link(d[5:0]);
      repeat (3) @(posedge clk_sys);
      rchk(8'h35, {2'b00, d[5:0]});
      chk(link_self_test_flag, d[5]);
      chk(partner_multi_input_capable, d[4]);
      chk(partner_port_num, d[3:0]);
      // own values go in with the freeze bit
      wr(8'h35, {2'b10, ~d[5:0]});
      partner.link(d[5:0] ^ 6'h15);
      repeat (3) @(posedge clk_sys);
      rchk(8'h35, {2'b10, ~d[5:0]});
      $display("capability test done");
      for (int k = 0; k < 2; k++) begin
         wr(8'h33, {5'h00, k == 0, 2'b00});
         outq.delete();
         foreach (b[i]) begin
            b[i] = 8'($urandom);
            seq_put(b[i]);
         end
         repeat (4) @(posedge clk_sys);
         chk(outq.size(), (k == 0) ? 9 : 8);
         foreach (b[i]) chk(outq[i], b[i]);
         if (k == 0) chk(outq[8], crc8(b));
         // One stall for the check word, none without it
         chk(n_stall, 1);
      end
      $display("sequence test done");
      // Mid-run reset: reset code gives the shortest interval
      rst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (9) @(posedge clk_sys);
      #1 chk(startup_active, 1'b1);
      @(posedge clk_sys);
      #1 chk(startup_active, 1'b0);
      rchk(8'h31, 8'h20);
      // Freeze cleared by reset, link still up, so caps reload
      rchk(8'h35, {2'b00, d[5:0] ^ 6'h15});
      $display("reset test done");
      report_and_stop();
   end
endmodule : lcrb_top_tb_top
